// ### pkg/ssm_pkg.sv
// Constants, types and register map of the clocked serial port block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package ssm_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RECEIVE_BUFFER    = 8'h04;
  localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_BAUD_CONTROL      = 8'h0C;
  localparam logic [7:0] ADDR_DIVISOR_HIGH      = 8'h10;
  localparam logic [7:0] ADDR_DIVISOR_LOW       = 8'h14;
  localparam logic [7:0] ADDR_TRANSMIT_BUFFER   = 8'h18;
  localparam logic [7:0] ADDR_FLAGS             = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE        = 8'h20;

  // Receive status/control bit positions
  localparam int RS_SERIAL_PORT_ENABLE = 7;
  localparam int RS_NINE_BIT_RECEIVE   = 6;
  localparam int RS_SINGLE_RECEIVE     = 5;
  localparam int RS_CONT_RECEIVE       = 4;
  localparam int RS_OVERRUN_ERROR      = 1;
  localparam int RS_NINTH_RECEIVED     = 0;

  // Transmit status/control bit positions
  localparam int TS_MASTER_CLOCK_SOURCE = 7;
  localparam int TS_NINE_BIT_TRANSMIT   = 6;
  localparam int TS_TRANSMIT_ENABLE     = 5;
  localparam int TS_CLOCKED_MODE        = 4;
  localparam int TS_SHIFTER_EMPTY       = 1;
  localparam int TS_NINTH_TRANSMIT      = 0;

  // Baud control, flag and interrupt enable bit positions
  localparam int BC_RECEIVE_IDLE        = 6;
  localparam int BC_CLOCK_IDLE_POLARITY = 4;
  localparam int BC_WIDE_DIVIDER        = 3;
  localparam int FL_RECEIVE_COMPLETE    = 5;
  localparam int FL_TX_BUFFER_EMPTY     = 4;

  // Reset values
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Word length steps
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  typedef enum logic [1:0] {SSM_IDLE, SSM_RX, SSM_TX} ssm_mode_e;

  // Index of last bit of a word
  function automatic logic [3:0] ssm_last_bit(input logic nine);
    ssm_last_bit = nine ? LAST_BIT_9 : LAST_BIT_8;
  endfunction

endpackage

// ### hw/ssm_brg.sv
// Divisor-driven tick generator for the master shift clock
`timescale 1ns/100ps
module ssm_brg
  import ssm_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // Control
  input  wire logic        EN,
  input  wire logic        WIDE,
  input  wire logic [15:0] DIV,
  // Half-period tick
  output logic             TICK
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ssm_brg_s;

  ssm_brg_s st_r;
  ssm_brg_s st_nxt;
  logic [15:0] limit;

  //----------------------------------------------------------------------------
  // Counter
  //----------------------------------------------------------------------------
  // Narrow mode ignores the high byte so old contents cannot stretch the rate
  assign limit = WIDE ? DIV : {8'h00, DIV[7:0]};

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!EN)
      st_nxt.cnt = 16'h0000;
    else if (st_r.cnt >= limit)
    begin
      st_nxt.cnt  = 16'h0000;
      st_nxt.tick = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 16'h0001;
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign TICK = st_r.tick;

endmodule

// ### hw/ssm_port.sv
// Clocked serial port: master receive, slave/master transmit, register slave
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module ssm_port
  import ssm_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Shift clock pin
  input  wire logic        SHIFT_CLOCK_PIN_I,
  output logic             SHIFT_CLOCK_PIN_O,
  output logic             SHIFT_CLOCK_PIN_OE,
  // Data pin
  input  wire logic        DATA_PIN_I,
  output logic             DATA_PIN_O,
  output logic             DATA_PIN_OE,
  // Power state and requests
  input  wire logic        SLEEP,
  output logic             RX_IRQ,
  output logic             TX_IRQ,
  output logic             WAKE
);

  typedef struct packed {
    // Bus slave
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    // Software registers
    logic        port_en;
    logic        rx9;
    logic        single_receive_enable;
    logic        continuous_receive_enable;
    logic        overrun_error;
    logic        ninth_received_bit;
    logic        master_clock_source;
    logic        tx9;
    logic        transmit_enable;
    logic        sync;
    logic        ninth_transmit_bit;
    logic        clock_idle_polarity;
    logic        wide_divider_select;
    logic [7:0]  div_hi;
    logic [7:0]  div_lo;
    logic        receive_complete_irq_enable;
    logic        transmit_buffer_empty_irq_enable;
    // Engine
    ssm_mode_e   mode;
    logic [7:0]  rx_buf;
    logic        receive_complete_flag;
    logic [7:0]  tx_buf;
    logic        tx_buf_full;
    logic        transmit_buffer_empty_flag;
    logic [8:0]  shifter;
    logic [3:0]  bit_cnt;
    logic        ck_active;
    logic        ck_in_d;
    logic        dt_out;
  } ssm_port_s;

  ssm_port_s   st_r;
  ssm_port_s   st_nxt;
  logic        brg_tick;
  logic        brg_en;
  logic        master;
  logic        cfg_ok;

  //----------------------------------------------------------------------------
  // Shift clock divider
  //----------------------------------------------------------------------------
  assign master = st_r.master_clock_source;
  assign cfg_ok = st_r.port_en & st_r.sync;
  // Divider only runs while a master word is being clocked
  assign brg_en = master & (st_r.mode != SSM_IDLE);

  ssm_brg u_brg (
    .CLK  (CLK),
    .NRST (NRST),
    .EN   (brg_en),
    .WIDE (st_r.wide_divider_select),
    .DIV  ({st_r.div_hi, st_r.div_lo}),
    .TICK (brg_tick)
  );

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    logic       wr_go;
    logic       rd_go;
    logic       trail;
    logic       rx_start;
    logic       tx_start;
    logic [3:0] last;
    st_nxt   = st_r;
    wr_go    = 1'b0;
    rd_go    = 1'b0;
    trail    = 1'b0;
    rx_start = 1'b0;
    tx_start = 1'b0;
    last     = 4'h0;

    // Write channels: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = S_AXI_WDATA[7:0];
      st_nxt.w_strb = S_AXI_WSTRB[0];
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
      st_nxt.bvalid = 1'b0;
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
    begin
      wr_go         = 1'b1;
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
    end

    // Register writes; only the low byte lane carries data
    if (wr_go)
    begin
      case (st_r.aw_addr)
        ADDR_RX_STATUS_CONTROL:
          if (st_r.w_strb)
          begin
            st_nxt.port_en = st_r.w_data[RS_SERIAL_PORT_ENABLE];
            st_nxt.rx9     = st_r.w_data[RS_NINE_BIT_RECEIVE];
            st_nxt.single_receive_enable    = st_r.w_data[RS_SINGLE_RECEIVE];
            st_nxt.continuous_receive_enable    = st_r.w_data[RS_CONT_RECEIVE];
            if (!st_r.w_data[RS_CONT_RECEIVE])
              st_nxt.overrun_error = 1'b0;
          end
        ADDR_TX_STATUS_CONTROL:
          if (st_r.w_strb)
          begin
            st_nxt.master_clock_source = st_r.w_data[TS_MASTER_CLOCK_SOURCE];
            st_nxt.tx9  = st_r.w_data[TS_NINE_BIT_TRANSMIT];
            st_nxt.transmit_enable = st_r.w_data[TS_TRANSMIT_ENABLE];
            st_nxt.sync = st_r.w_data[TS_CLOCKED_MODE];
            st_nxt.ninth_transmit_bit = st_r.w_data[TS_NINTH_TRANSMIT];
          end
        ADDR_BAUD_CONTROL:
          if (st_r.w_strb)
          begin
            st_nxt.clock_idle_polarity  = st_r.w_data[BC_CLOCK_IDLE_POLARITY];
            st_nxt.wide_divider_select = st_r.w_data[BC_WIDE_DIVIDER];
          end
        ADDR_DIVISOR_HIGH:
          if (st_r.w_strb)
            st_nxt.div_hi = st_r.w_data;
        ADDR_DIVISOR_LOW:
          if (st_r.w_strb)
            st_nxt.div_lo = st_r.w_data;
        ADDR_TRANSMIT_BUFFER:
          if (st_r.w_strb)
          begin
            st_nxt.tx_buf      = st_r.w_data;
            st_nxt.tx_buf_full = 1'b1;
            st_nxt.transmit_buffer_empty_flag        = 1'b0;
          end
        ADDR_IRQ_ENABLE:
          if (st_r.w_strb)
          begin
            st_nxt.receive_complete_irq_enable = st_r.w_data[FL_RECEIVE_COMPLETE];
            st_nxt.transmit_buffer_empty_irq_enable = st_r.w_data[FL_TX_BUFFER_EMPTY];
          end
        ADDR_RECEIVE_BUFFER,
        ADDR_FLAGS:
          st_nxt.bresp = RESP_OKAY;
        default:
          st_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // Read channel; read data is captured when the address is taken
    if (S_AXI_RVALID && S_AXI_RREADY)
      st_nxt.rvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rd_go         = 1'b1;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      case (S_AXI_ARADDR)
        ADDR_RX_STATUS_CONTROL:
          st_nxt.rdata[7:0] = {st_r.port_en, st_r.rx9, st_r.single_receive_enable,
                               st_r.continuous_receive_enable, 2'b00, st_r.overrun_error, st_r.ninth_received_bit};
        ADDR_RECEIVE_BUFFER:
        begin
          st_nxt.rdata[7:0] = st_r.rx_buf;
          st_nxt.receive_complete_flag       = 1'b0;
        end
        ADDR_TX_STATUS_CONTROL:
          st_nxt.rdata[7:0] = {st_r.master_clock_source, st_r.tx9, st_r.transmit_enable, st_r.sync,
                               2'b00, (st_r.mode != SSM_TX), st_r.ninth_transmit_bit};
        ADDR_BAUD_CONTROL:
          st_nxt.rdata[7:0] = {1'b0, (st_r.mode != SSM_RX), 1'b0,
                               st_r.clock_idle_polarity, st_r.wide_divider_select, 3'b000};
        ADDR_DIVISOR_HIGH:
          st_nxt.rdata[7:0] = st_r.div_hi;
        ADDR_DIVISOR_LOW:
          st_nxt.rdata[7:0] = st_r.div_lo;
        ADDR_TRANSMIT_BUFFER:
          st_nxt.rdata[7:0] = st_r.tx_buf;
        ADDR_FLAGS:
          st_nxt.rdata[7:0] = {2'b00, st_r.receive_complete_flag, st_r.transmit_buffer_empty_flag, 4'h0};
        ADDR_IRQ_ENABLE:
          st_nxt.rdata[7:0] = {2'b00, st_r.receive_complete_irq_enable, st_r.transmit_buffer_empty_irq_enable, 4'h0};
        default:
          st_nxt.rresp = RESP_SLVERR;
      endcase
    end

    // Clock edges: generated in master mode, taken from the pin in slave mode
    st_nxt.ck_in_d = SHIFT_CLOCK_PIN_I;
    if (master)
    begin
      if (st_r.mode == SSM_IDLE)
        st_nxt.ck_active = 1'b0;
      else if (brg_tick)
      begin
        st_nxt.ck_active = !st_r.ck_active;
        trail            = st_r.ck_active;
      end
    end
    else
    begin
      st_nxt.ck_active = 1'b0;
      // Slave edges run on the pin alone, so sleep does not stop them
      trail = (SHIFT_CLOCK_PIN_I != st_r.ck_in_d)
            && (SHIFT_CLOCK_PIN_I == st_r.clock_idle_polarity);
    end

    // Engine
    case (st_r.mode)
      SSM_IDLE:
      begin
        st_nxt.bit_cnt = 4'h0;
        // Pending transmit wins; a receive only starts from idle
        tx_start = cfg_ok && st_r.transmit_enable && st_r.tx_buf_full;
        rx_start = cfg_ok && master && !st_r.overrun_error
                && (st_r.single_receive_enable || st_r.continuous_receive_enable) && !tx_start;
        if (rx_start)
          st_nxt.mode = SSM_RX;
      end
      SSM_RX:
      begin
        last = ssm_last_bit(st_r.rx9);
        if (!cfg_ok || !master || !(st_r.single_receive_enable || st_r.continuous_receive_enable))
          st_nxt.mode = SSM_IDLE;
        else if (trail)
        begin
          st_nxt.shifter[st_r.bit_cnt] = DATA_PIN_I;
          if (st_r.bit_cnt == last)
          begin
            st_nxt.bit_cnt = 4'h0;
            // An unread word is kept; the newcomer is lost
            if (st_r.receive_complete_flag && st_nxt.receive_complete_flag)
              st_nxt.overrun_error = 1'b1;
            else
            begin
              st_nxt.rx_buf = {DATA_PIN_I, st_r.shifter[6:0]};
              if (st_r.rx9)
              begin
                st_nxt.rx_buf = st_r.shifter[7:0];
                st_nxt.ninth_received_bit   = DATA_PIN_I;
              end
              st_nxt.receive_complete_flag = 1'b1;
            end
            if (!st_r.continuous_receive_enable)
            begin
              st_nxt.single_receive_enable = 1'b0;
              st_nxt.mode = SSM_IDLE;
            end
            else if (st_nxt.overrun_error)
              st_nxt.mode = SSM_IDLE;
          end
          else
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        end
      end
      SSM_TX:
      begin
        last = ssm_last_bit(st_r.tx9);
        if (!cfg_ok || !st_r.transmit_enable)
          st_nxt.mode = SSM_IDLE;
        else if (trail)
        begin
          if (st_r.bit_cnt == last)
          begin
            st_nxt.bit_cnt = 4'h0;
            // Back-to-back reload keeps the line busy with no idle gap
            tx_start = st_r.tx_buf_full;
            if (!tx_start)
              st_nxt.mode = SSM_IDLE;
          end
          else
          begin
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
            st_nxt.dt_out  = st_r.shifter[st_r.bit_cnt + 4'h1];
          end
        end
      end
      default:
        st_nxt.mode = SSM_IDLE;
    endcase

    // Buffer to shifter move; apart from reset, flag sets here and nowhere else
    if (tx_start)
    begin
      st_nxt.mode        = SSM_TX;
      st_nxt.bit_cnt     = 4'h0;
      st_nxt.shifter     = {st_r.ninth_transmit_bit, st_r.tx_buf};
      st_nxt.dt_out      = st_r.tx_buf[0];
      st_nxt.tx_buf_full = 1'b0;
      st_nxt.transmit_buffer_empty_flag        = 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      st_r         <= '0;
      st_r.mode    <= SSM_IDLE;
      st_r.div_hi  <= RST_DIVISOR;
      st_r.div_lo  <= RST_DIVISOR;
      st_r.tx_buf  <= RST_CONTROL;
      st_r.rx_buf  <= RST_CONTROL;
      st_r.transmit_buffer_empty_flag    <= 1'b1; // Buffer starts empty
      st_r.ck_in_d <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign S_AXI_AWREADY = !st_r.aw_got && !st_r.bvalid;
  assign S_AXI_WREADY  = !st_r.w_got && !st_r.bvalid;
  assign S_AXI_BVALID  = st_r.bvalid;
  assign S_AXI_BRESP   = st_r.bresp;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign S_AXI_RVALID  = st_r.rvalid;
  assign S_AXI_RDATA   = st_r.rdata;
  assign S_AXI_RRESP   = st_r.rresp;

  // Master drives the clock; idle level is the polarity bit
  assign SHIFT_CLOCK_PIN_O  = st_r.clock_idle_polarity ^ st_r.ck_active;
  assign SHIFT_CLOCK_PIN_OE = cfg_ok && master;
  assign DATA_PIN_O         = st_r.dt_out;
  assign DATA_PIN_OE        = cfg_ok && (st_r.mode == SSM_TX);

  // Flags raise requests only through their enables
  assign RX_IRQ = st_r.receive_complete_flag && st_r.receive_complete_irq_enable;
  assign TX_IRQ = st_r.transmit_buffer_empty_flag && st_r.transmit_buffer_empty_irq_enable;
  assign WAKE   = SLEEP && (RX_IRQ || TX_IRQ);

endmodule

// ### test/ssm_port_props.sv
// Port-level assertions and covers for the clocked serial port
`timescale 1ns/100ps
module ssm_port_props
  import ssm_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // Register bus answers
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // Power and requests
  input wire logic        SLEEP,
  input wire logic        RX_IRQ,
  input wire logic        TX_IRQ,
  input wire logic        WAKE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  // Answers stand until taken and hold off new requests meanwhile
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  a_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("bvalid stuck");
  a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY
    && !S_AXI_WREADY) else $error("write taken during response");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  a_rdata_upper: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  // A flag only falls through a bus access, never on its own
  a_rx_clear: assert property ($fell(RX_IRQ) |->
    $past(S_AXI_ARVALID && S_AXI_ARREADY) || S_AXI_BVALID)
    else $error("receive request fell unprompted");
  a_tx_clear: assert property ($fell(TX_IRQ) |-> S_AXI_BVALID)
    else $error("transmit request fell without a write");
  a_wake_join: assert property (
    WAKE == (SLEEP && (RX_IRQ || TX_IRQ))) else $error("wake wrong");

  // Main scenarios reached
  c_rx_done: cover property ($rose(RX_IRQ));
  c_tx_sleep: cover property ($rose(TX_IRQ) && SLEEP);
  c_wake: cover property ($rose(WAKE));
endmodule

bind ssm_port ssm_port_props u_props (.CLK, .NRST, .S_AXI_AWREADY,
  .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .S_AXI_RREADY, .SLEEP, .RX_IRQ, .TX_IRQ, .WAKE);

// ### test/ssm_peer.sv
// Peer serial device model facing the port's clock and data pins
`timescale 1ns/100ps
module ssm_peer
(
  // Bench controls
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        pol,
  input  wire logic [3:0]  last,
  input  wire logic [8:0]  word,
  input  wire logic [4:0]  run_bits,
  // Port pins
  input  wire logic        ck_o,
  input  wire logic        ck_oe,
  input  wire logic        dat_o,
  input  wire logic        dat_oe,
  output logic             ck_i,
  output logic             dat_i,
  output logic [17:0]      cap
);
  logic       ck_q = 1'b0;
  logic       sck  = 1'b0;
  logic       tog  = 1'b0;
  logic [3:0] idx  = 4'h0;
  logic [4:0] left = 5'h00;
  logic [1:0] div  = 2'h0;

  // Port drivers win; an undriven data line wanders so stale values show
  assign ck_i  = ck_oe ? ck_o : sck;
  assign dat_i = dat_oe ? dat_o : (ck_oe ? word[idx] : tog);

  // Next bit only after the sampling edge, so data is steady across it
  always @(posedge clk)
  begin
    ck_q <= ck_o;
    tog  <= ~tog;
    if (clr)
      idx <= 4'h0;
    else if (ck_oe && ck_q != pol && ck_o == pol)
      idx <= (idx == last) ? 4'h0 : idx + 4'h1;
  end

  // Slave clock runs only for the bits asked, then rests at idle level
  always @(posedge clk)
  begin
    div <= div + 2'h1;
    if (clr)
    begin
      left <= run_bits;
      sck  <= pol;
    end
    else if (left != 5'h00 && div == 2'h3)
    begin
      sck <= ~sck;
      // Capture on the return to idle, as any receiver on this link must
      if (sck != pol)
      begin
        cap  <= {dat_o, cap[17:1]};
        left <= left - 5'h1;
      end
    end
  end
endmodule

// ### test/ssm_port_bench.sv
// Self-checking bench: register bus, master receive, slave transmit
`timescale 1ns/100ps
module ssm_port_bench
  import ssm_pkg::*;
;
  logic        clk = 1'b0, nrst = 1'b0, sleep = 1'b0, clr = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, pol = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rv, n, w1, w2;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  last = LAST_BIT_8;
  logic [8:0]  word = 9'h000, wexp;
  logic [4:0]  run_bits = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid, cki, dati;
  logic        cko, ckoe, dato, datoe, rxirq, txirq, wake;
  logic [1:0]  bresp, rresp;
  logic [17:0] cap;
  int          err_total = 0, total_checks = 0, cyc = 0, h, seed;

  always #10 clk = ~clk;

  ssm_port u_dut (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SHIFT_CLOCK_PIN_I(cki), .SHIFT_CLOCK_PIN_O(cko),
    .SHIFT_CLOCK_PIN_OE(ckoe), .DATA_PIN_I(dati), .DATA_PIN_O(dato),
    .DATA_PIN_OE(datoe), .SLEEP(sleep), .RX_IRQ(rxirq), .TX_IRQ(txirq),
    .WAKE(wake));

  ssm_peer u_peer (.clk, .clr, .pol, .last, .word, .run_bits,
    .ck_o(cko), .ck_oe(ckoe), .dat_o(dato), .dat_oe(datoe),
    .ck_i(cki), .dat_i(dati), .cap);

  task automatic end_of_test();
  begin
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  // Each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = RESP_OKAY);
  begin
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  end
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
  begin
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rv = rdata[7:0];
    chk("rresp", rresp, er);
  end
  endtask

  // Peer index and slave clock restart; hides mode-switch glitches
  task automatic pclr();
  begin
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  end
  endtask

  // Hang guard, far above the longest wide-divider word
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  initial
  begin
    seed = 25706;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_FLAGS);
    chk("flags_rst", rv, 8'h10);
    rd(8'h24, RESP_SLVERR);
    wr(8'h28, 8'h5A, RESP_SLVERR);
    // Single receive, narrow then wide divider, both polarities
    for (int i = 0; i < 2; i++)
    begin
      n = 8'($random(seed)) & 8'h03 | 8'h01;
      word <= 9'($random(seed));
      pol <= i[0];
      last <= i ? LAST_BIT_9 : LAST_BIT_8;
      wr(ADDR_DIVISOR_HIGH, 8'h01);
      wr(ADDR_DIVISOR_LOW, n);
      wr(ADDR_BAUD_CONTROL, {3'h0, i[0], i[0], 3'h0});
      wr(ADDR_TX_STATUS_CONTROL, 8'h90);
      wr(ADDR_IRQ_ENABLE, 8'h20);
      wr(ADDR_RX_STATUS_CONTROL, {1'b1, i[0], 6'h00});
      pclr();
      chk("ck_idle", cko, pol);
      chk("ck_oe", ckoe, 1'b1);
      wr(ADDR_RX_STATUS_CONTROL, {1'b1, i[0], 6'h20});
      h = 0;
      repeat (2000) if (cko === pol) @(posedge clk);
      repeat (2000) if (cko !== pol)
      begin
        @(posedge clk);
        h++;
      end
      chk("half", h, i ? 257 + n : n + 1);
      chk("data_oe", datoe, 1'b0);
      repeat (6000) if (rxirq !== 1'b1) @(posedge clk);
      chk("rx_irq", rxirq, 1'b1);
      rd(ADDR_RX_STATUS_CONTROL);
      chk("rx_ctl", rv, {1'b1, i[0], 5'h00, i[0] & word[8]});
      rd(ADDR_RECEIVE_BUFFER);
      chk("rx_word", rv, word[7:0]);
      chk("rx_irq_clr", rxirq, 1'b0);
      chk("ck_rest", cko, pol);
    end
    // Both enables: continuous wins, then overrun keeps the unread word
    pol <= 1'b0;
    last <= LAST_BIT_8;
    wr(ADDR_BAUD_CONTROL, 8'h00);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    pclr();
    wr(ADDR_RX_STATUS_CONTROL, 8'hB0);
    for (int k = 0; k < 2; k++)
    begin
      repeat (800) if (rxirq !== 1'b1) @(posedge clk);
      rd(ADDR_RECEIVE_BUFFER);
      chk("cont_word", rv, word[7:0]);
    end
    repeat (800) if (rxirq !== 1'b1) @(posedge clk);
    wexp = word;
    word <= ~word;
    rv = 8'h00;
    repeat (40) if (rv[1] !== 1'b1) rd(ADDR_RX_STATUS_CONTROL);
    chk("overrun", rv[1], 1'b1);
    rd(ADDR_RECEIVE_BUFFER);
    chk("kept_word", rv, wexp[7:0]);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    rd(ADDR_RX_STATUS_CONTROL);
    chk("overrun_clr", rv[1], 1'b0);
    // Slave transmit of two queued nine-bit words while asleep
    wr(ADDR_TX_STATUS_CONTROL, 8'h71);
    chk("ck_oe_slave", ckoe, 1'b0);
    wr(ADDR_IRQ_ENABLE, 8'h10);
    w1 = 8'($random(seed));
    w2 = 8'($random(seed));
    wr(ADDR_TRANSMIT_BUFFER, w1);
    wr(ADDR_TRANSMIT_BUFFER, w2);
    chk("tx_busy", datoe, 1'b1);
    sleep <= 1'b1;
    run_bits <= 5'h12;
    pclr();
    chk("tx_irq_held", txirq, 1'b0);
    chk("wake_held", wake, 1'b0);
    repeat (400) if (txirq !== 1'b1) @(posedge clk);
    chk("tx_irq", txirq, 1'b1);
    chk("first_out", cap[17:9], {1'b1, w1});
    chk("wake", wake, 1'b1);
    repeat (400) if (cap !== {1'b1, w2, 1'b1, w1}) @(posedge clk);
    chk("shifted", cap, {1'b1, w2, 1'b1, w1});
    rd(ADDR_FLAGS);
    chk("flags_end", rv, 8'h10);
    end_of_test();
  end
endmodule
